// ### pbs_pkg.sv
// pbs_pkg: constants, field layout and types of the pattern block sequencer
// assumes a 10 MHz mclk and a word-indexed register port
package pbs_pkg;
	// ------------------------------------------------------------
	// sizes
	// ------------------------------------------------------------
	localparam int NBLK = 8;
	localparam int IW = 3;
	localparam int AW = 5;
	localparam int DW = 32;
	localparam int VAL_W = 16;
	localparam int PSEL_W = 4;
	localparam int SLEN_W = 8;
	localparam int SINT_W = 16;
	localparam int US_W = 4;
	// ------------------------------------------------------------
	// register indices (block i sits at index i)
	// ------------------------------------------------------------
	localparam logic [AW-1:0] A_CTRL = 5'h10;
	localparam logic [AW-1:0] A_SKIP = 5'h11;
	localparam logic [AW-1:0] A_STAT = 5'h12;
	localparam logic [AW-1:0] A_CMD = 5'h13;
	// ------------------------------------------------------------
	// block word fields
	// ------------------------------------------------------------
	localparam int F_VAL = 0;
	localparam int F_TIME = 16;
	localparam int F_BRK = 17;
	localparam int F_GEN = 19;
	localparam int F_SKI = 20;
	localparam int F_SKR = 21;
	localparam int F_PSEL = 22;
	localparam int BLK_W = 26;
	// ------------------------------------------------------------
	// control, skip, status and command fields
	// ------------------------------------------------------------
	localparam int C_RUN = 0;
	localparam int C_LAST = 1;
	localparam int C_USB = 4;
	localparam int C_LFPS = 5;
	localparam int C_W = 6;
	localparam int S_LEN = 0;
	localparam int S_INT = 8;
	localparam int S_W = 24;
	localparam int ST_IDX = 0;
	localparam int ST_RUN = 3;
	localparam int ST_HOLD = 4;
	localparam int ST_DONE = 5;
	localparam int CMD_ADV = 0;
	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [BLK_W-1:0] RST_BLK = 26'h0000000;
	localparam logic [C_W-1:0] RST_CTRL = 6'h0e;
	localparam logic [S_W-1:0] RST_SKIP = 24'h000000;
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_NS = 100;
	localparam int US_NS = 1000;
	localparam int CYC_US_I = (US_NS / CLK_NS) < 1 ? 1 : (US_NS / CLK_NS);
	localparam logic [US_W-1:0] CYC_US = US_W'(CYC_US_I);
	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		BRK_NONE = 2'b00,
		BRK_MAN = 2'b01,
		BRK_EXT = 2'b10
	} pbs_brk_t;
	typedef enum logic [1:0] {
		SQ_IDLE = 2'b00,
		SQ_PLAY = 2'b01,
		SQ_HOLD = 2'b10,
		SQ_DONE = 2'b11
	} pbs_state_t;
endpackage

// ### pbs_trig.sv
// pbs_trig: external break trigger detector
// assumes aux and lfps pins are asynchronous to mclk
`timescale 1ns/1ps
`default_nettype none
module pbs_trig
	import pbs_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// pins
	input wire logic aux_pin,
	input wire logic lfps_pin,
	// selection
	input wire logic usb_sel,
	input wire logic lfps_sel,
	// event
	output logic trig
);
	logic [2:0] aux_r, aux_nxt;
	logic [2:0] lfps_r, lfps_nxt;
	logic trig_r, trig_nxt;

	always_comb begin
		aux_nxt = {aux_r[1:0], aux_pin};
		lfps_nxt = {lfps_r[1:0], lfps_pin};
		// usb selects lfps reception or plain edge
		if (usb_sel && lfps_sel) begin // [RULE_04]
			trig_nxt = lfps_r[1] && !lfps_r[2];
		end else begin
			trig_nxt = aux_r[1] && !aux_r[2];
		end
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			aux_r <= 3'h0;
			lfps_r <= 3'h0;
			trig_r <= 1'b0;
		end else begin
			aux_r <= aux_nxt;
			lfps_r <= lfps_nxt;
			trig_r <= trig_nxt;
		end
	end

	assign trig = trig_r;
endmodule // pbs_trig
`default_nettype wire

// ### pbs_seq.sv
// pbs_seq: pattern block sequencer top
// assumes pat_done and sym_tick come from the pattern engine on mclk
//
// Behaviour
// RULE_01: each block's break setting decides pausing after it and how it resumes.
// RULE_02: manual break holds the block until an operator advance command.
// RULE_03: external break holds the block until the auxiliary trigger fires.
// RULE_04: with usb selected the trigger is lfps reception or an edge.
// RULE_05: software should put electrical idle between blocks of differing bitrate.
// RULE_06: general pattern type is honoured only on the final block.
// RULE_07: each block repeats by count or by duration.
// RULE_08: block value is a count, or microseconds in time mode.
// RULE_09: periodic skip sets follow global length and interval settings.
// RULE_10: skip restart emits a skip set at the start of the next block.
// RULE_11: blocks play in order, advancing on completion when no break holds.
`timescale 1ns/1ps
`default_nettype none
module pbs_seq
	import pbs_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// register port
	input wire logic [AW-1:0] addr,
	input wire logic [DW-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [DW-1:0] rdata,
	// pattern engine
	input wire logic pat_done,
	input wire logic sym_tick,
	output logic [IW-1:0] cur_blk,
	output logic [PSEL_W-1:0] pat_sel,
	output logic pat_general,
	output logic playing,
	output logic skip_req,
	output logic [SLEN_W-1:0] skip_len,
	// trigger pins
	input wire logic aux_pin,
	input wire logic lfps_pin
);
	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	logic [BLK_W-1:0] blk_r [NBLK];
	logic [BLK_W-1:0] blk_nxt [NBLK];
	logic [C_W-1:0] ctrl_r, ctrl_nxt;
	logic [S_W-1:0] skip_r, skip_nxt;
	logic [DW-1:0] rdata_r, rdata_nxt;
	logic adv_cmd;
	logic [IW-1:0] last_idx;

	assign last_idx = ctrl_r[C_LAST +: IW];
	assign adv_cmd = wr && (addr == A_CMD) && wdata[CMD_ADV];

	genvar gi;
	generate
		for (gi = 0; gi < NBLK; gi++) begin : g_blk
			always_comb begin
				blk_nxt[gi] = blk_r[gi];
				if (wr && (addr == AW'(gi))) begin
					blk_nxt[gi] = wdata[BLK_W-1:0];
				end
			end
			always_ff @(posedge mclk) begin
				if (!rstn) begin
					blk_r[gi] <= RST_BLK;
				end else begin
					blk_r[gi] <= blk_nxt[gi];
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// sequencer state
	// ------------------------------------------------------------
	pbs_state_t st_r, st_nxt;
	logic [IW-1:0] idx_r, idx_nxt;
	logic [VAL_W-1:0] rep_r, rep_nxt;
	logic [US_W-1:0] us_r, us_nxt;
	logic [SINT_W-1:0] scnt_r, scnt_nxt;
	logic skip_req_r, skip_req_nxt;
	logic [PSEL_W-1:0] psel_r, psel_nxt;
	logic gen_r, gen_nxt;
	logic trig;
	logic [BLK_W-1:0] cb;
	logic [BLK_W-1:0] nb;
	logic us_tick, unit_evt, blk_end, resume, at_last, step;
	logic [VAL_W-1:0] rep_inc;
	logic [SINT_W-1:0] scnt_inc;
	pbs_brk_t brk;

	pbs_trig u_trig (
		.mclk(mclk),
		.rstn(rstn),
		.aux_pin(aux_pin),
		.lfps_pin(lfps_pin),
		.usb_sel(ctrl_r[C_USB]),
		.lfps_sel(ctrl_r[C_LFPS]),
		.trig(trig)
	);

	assign cb = blk_r[idx_r];
	assign nb = blk_r[IW'(idx_r + 1'b1)];
	assign brk = pbs_brk_t'(cb[F_BRK +: $bits(pbs_brk_t)]);
	assign at_last = (idx_r == last_idx);
	assign us_tick = (us_r == CYC_US - 1'b1);
	assign rep_inc = rep_r + 1'b1;
	assign scnt_inc = scnt_r + 1'b1;
	// unit of repetition: a full pattern or one microsecond
	assign unit_evt = cb[F_TIME] ? us_tick : pat_done; // [RULE_07]
	assign blk_end = unit_evt && (rep_inc >= cb[F_VAL +: VAL_W]); // [RULE_08]
	assign resume = (brk == BRK_MAN) ? adv_cmd : // [RULE_02]
		(brk == BRK_EXT) ? trig : 1'b1; // [RULE_03]

	always_comb begin
		st_nxt = st_r;
		idx_nxt = idx_r;
		rep_nxt = rep_r;
		us_nxt = us_tick ? '0 : US_W'(us_r + 1'b1);
		scnt_nxt = scnt_r;
		skip_req_nxt = 1'b0;
		step = 1'b0;
		case (st_r)
			SQ_IDLE: begin
				us_nxt = '0;
				if (ctrl_r[C_RUN]) begin
					st_nxt = SQ_PLAY;
					idx_nxt = '0;
					rep_nxt = '0;
					scnt_nxt = '0;
				end
			end
			SQ_PLAY: begin
				if (unit_evt) begin
					rep_nxt = rep_inc;
				end
				if (blk_end) begin
					if (brk != BRK_NONE) begin
						st_nxt = SQ_HOLD; // [RULE_01]
					end else begin
						step = 1'b1; // [RULE_11]
					end
				end
			end
			SQ_HOLD: begin
				if (resume) begin
					step = 1'b1;
				end
			end
			SQ_DONE: begin
				us_nxt = '0;
			end
			default: begin
				st_nxt = SQ_IDLE;
			end
		endcase
		if (step) begin
			rep_nxt = '0;
			us_nxt = '0;
			if (at_last) begin
				st_nxt = SQ_DONE;
			end else begin
				st_nxt = SQ_PLAY;
				idx_nxt = IW'(idx_r + 1'b1);
			end
		end
		// periodic skip sets while the block plays
		if ((st_r == SQ_PLAY || st_r == SQ_HOLD) && cb[F_SKI] && sym_tick) begin
			if (scnt_inc >= skip_r[S_INT +: SINT_W]) begin // [RULE_09]
				scnt_nxt = '0;
				skip_req_nxt = 1'b1;
			end else begin
				scnt_nxt = scnt_inc;
			end
		end
		if (step && !at_last && nb[F_SKR]) begin
			scnt_nxt = '0; // [RULE_10]
			skip_req_nxt = 1'b1;
		end
		if (!ctrl_r[C_RUN]) begin
			st_nxt = SQ_IDLE;
			skip_req_nxt = 1'b0;
		end
		psel_nxt = blk_r[idx_nxt][F_PSEL +: PSEL_W];
		// general only counts on the final block
		gen_nxt = blk_r[idx_nxt][F_GEN] && (idx_nxt == last_idx); // [RULE_06]
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			st_r <= SQ_IDLE;
			idx_r <= '0;
			rep_r <= '0;
			us_r <= '0;
			scnt_r <= '0;
			skip_req_r <= 1'b0;
			psel_r <= '0;
			gen_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			idx_r <= idx_nxt;
			rep_r <= rep_nxt;
			us_r <= us_nxt;
			scnt_r <= scnt_nxt;
			skip_req_r <= skip_req_nxt;
			psel_r <= psel_nxt;
			gen_r <= gen_nxt;
		end
	end

	// ------------------------------------------------------------
	// global registers and read path
	// ------------------------------------------------------------
	always_comb begin
		ctrl_nxt = ctrl_r;
		skip_nxt = skip_r;
		rdata_nxt = '0;
		if (wr && addr == A_CTRL) begin
			ctrl_nxt = wdata[C_W-1:0];
		end
		if (wr && addr == A_SKIP) begin
			skip_nxt = wdata[S_W-1:0];
		end
		if (rd) begin
			if (addr < AW'(NBLK)) begin
				rdata_nxt[BLK_W-1:0] = blk_r[addr[IW-1:0]];
			end else if (addr == A_CTRL) begin
				rdata_nxt[C_W-1:0] = ctrl_r;
			end else if (addr == A_SKIP) begin
				rdata_nxt[S_W-1:0] = skip_r;
			end else if (addr == A_STAT) begin
				rdata_nxt[ST_IDX +: IW] = idx_r;
				rdata_nxt[ST_RUN] = (st_r == SQ_PLAY) || (st_r == SQ_HOLD);
				rdata_nxt[ST_HOLD] = (st_r == SQ_HOLD);
				rdata_nxt[ST_DONE] = (st_r == SQ_DONE);
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			ctrl_r <= RST_CTRL;
			skip_r <= RST_SKIP;
			rdata_r <= '0;
		end else begin
			ctrl_r <= ctrl_nxt;
			skip_r <= skip_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign rdata = rdata_r;
	assign cur_blk = idx_r;
	assign pat_sel = psel_r;
	assign pat_general = gen_r;
	assign playing = (st_r == SQ_PLAY) || (st_r == SQ_HOLD);
	assign skip_req = skip_req_r;
	assign skip_len = skip_r[S_LEN +: SLEN_W];

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb_m @(posedge mclk); endclocking
	default disable iff (!rstn);

	property p_hold_stays;
		st_r == SQ_HOLD && ctrl_r[C_RUN] && !resume |=> st_r == SQ_HOLD && $stable(idx_r);
	endproperty
	a_hold_stays: assert property (p_hold_stays) else $error("held block moved"); // [RULE_01]

	property p_man_adv;
		st_r == SQ_HOLD && brk == BRK_MAN && adv_cmd && !at_last && ctrl_r[C_RUN]
			|=> idx_r == IW'($past(idx_r) + 1'b1) && st_r == SQ_PLAY;
	endproperty
	a_man_adv: assert property (p_man_adv) else $error("manual advance lost"); // [RULE_02]

	property p_ext_adv;
		st_r == SQ_HOLD && brk == BRK_EXT && trig && !at_last && ctrl_r[C_RUN]
			|=> idx_r == IW'($past(idx_r) + 1'b1);
	endproperty
	a_ext_adv: assert property (p_ext_adv) else $error("trigger advance lost"); // [RULE_03]

	property p_ext_no_cmd;
		st_r == SQ_HOLD && brk == BRK_EXT && adv_cmd && !trig |=> st_r == SQ_HOLD;
	endproperty
	a_ext_no_cmd: assert property (p_ext_no_cmd) else $error("command left ext break"); // [RULE_03]

	property p_gen_last;
		pat_general |-> cur_blk == last_idx || $changed(last_idx);
	endproperty
	a_gen_last: assert property (p_gen_last) else $error("general off final block"); // [RULE_06]

	property p_cnt_end;
		st_r == SQ_PLAY && !cb[F_TIME] && pat_done && brk == BRK_NONE && !at_last
			&& ctrl_r[C_RUN] && rep_inc >= cb[F_VAL +: VAL_W]
			|=> idx_r == IW'($past(idx_r) + 1'b1) && rep_r == '0;
	endproperty
	a_cnt_end: assert property (p_cnt_end) else $error("count end missed"); // [RULE_11]

	property p_time_us;
		st_r == SQ_PLAY && cb[F_TIME] && ctrl_r[C_RUN] && us_r == '0
			&& cb[F_VAL +: VAL_W] > 16'h0001 && rep_r == '0
			|-> ##1 st_r == SQ_PLAY [*8];
	endproperty
	a_time_us: assert property (p_time_us) else $error("time block ended early"); // [RULE_08]

	property p_skip_restart;
		step && !at_last && nb[F_SKR] && ctrl_r[C_RUN] |=> skip_req && scnt_r == '0;
	endproperty
	a_skip_restart: assert property (p_skip_restart) else $error("no skip at block start"); // [RULE_10]

	property p_skip_play;
		skip_req |-> $past(st_r) == SQ_PLAY || $past(st_r) == SQ_HOLD;
	endproperty
	a_skip_play: assert property (p_skip_play) else $error("skip while idle"); // [RULE_09]
endmodule // pbs_seq
`default_nettype wire

// ### pbs_engine_model.sv
// pbs_engine_model: pattern engine stand-in
// assumes mclk domain; the pattern restarts whenever the block changes
`timescale 1ns/1ps
`default_nettype none
module pbs_engine_model
	import pbs_pkg::*;
#(
	parameter int PLEN = 4
)
(
	// clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// from sequencer
	input wire logic playing,
	input wire logic [IW-1:0] cur_blk,
	// pacing: one symbol every cycle, or every other cycle
	input wire logic slow,
	// to sequencer
	output logic pat_done,
	output logic sym_tick
);
	// ------------------------------------------------------------
	// symbol and repetition pacing
	// ------------------------------------------------------------
	int nsym;
	logic phase;
	logic [IW-1:0] last_blk;
	always_ff @(posedge mclk) begin
		pat_done <= 1'b0;
		sym_tick <= 1'b0;
		last_blk <= cur_blk;
		if (!rstn || !playing || cur_blk != last_blk) begin
			nsym <= 0;
			phase <= 1'b0;
		end else begin
			phase <= ~phase;
			if (!slow || phase) begin
				sym_tick <= 1'b1;
				nsym <= (nsym + 1) % PLEN;
				pat_done <= (nsym == PLEN - 1);
			end
		end
	end
endmodule // pbs_engine_model
`default_nettype wire

// ### pbs_seq_bench.sv
// pbs_seq_bench: self-checking bench for the pattern block sequencer
// assumes pbs_engine_model on the pattern side and a 10 MHz mclk
`timescale 1ns/1ps
`default_nettype none
module pbs_seq_bench
	import pbs_pkg::*;
;
	typedef struct {int blk; int done; int cyc; int sel; int gen; int first; int skp;} pbs_rec_t;
	logic mclk, rstn, wr, rd, pat_done, sym_tick, aux_pin, lfps_pin, slow;
	logic pat_general, playing, skip_req, m_on;
	logic [AW-1:0] addr;
	logic [DW-1:0] wdata, rdata, d;
	logic [IW-1:0] cur_blk;
	logic [PSEL_W-1:0] pat_sel;
	logic [SLEN_W-1:0] skip_len;
	int num_errors, total_checks, cycles, exp_len, last_sk, seed;
	int bval[NBLK], bsel[NBLK], bbrk[NBLK], bflg[NBLK], gaps[$];
	pbs_rec_t cur;
	pbs_rec_t recs[$];
	pbs_seq u_pbs_seq(.mclk(mclk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .pat_done(pat_done), .sym_tick(sym_tick), .cur_blk(cur_blk),
		.pat_sel(pat_sel), .pat_general(pat_general), .playing(playing), .skip_req(skip_req),
		.skip_len(skip_len), .aux_pin(aux_pin), .lfps_pin(lfps_pin));
	pbs_engine_model #(.PLEN(4)) u_pbs_engine_model(.mclk(mclk), .rstn(rstn), .playing(playing),
		.cur_blk(cur_blk), .slow(slow), .pat_done(pat_done), .sym_tick(sym_tick));
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic wr_reg(input logic [AW-1:0] a, input logic [DW-1:0] v);
		@(posedge mclk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [AW-1:0] a, output logic [DW-1:0] v);
		@(posedge mclk);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		@(posedge mclk);
		v = rdata;
	endtask
	task automatic set_blk(input int k);
		wr_reg(AW'(k), DW'(bval[k] | (bflg[k] & 1) << 16 | bbrk[k] << 17
			| (bflg[k] >> 1) << 19 | bsel[k] << 22));
	endtask
	task automatic poll(input int bitn);
		logic [DW-1:0] v;
		v = '0;
		for (int n = 0; n < 300 && v[bitn] !== 1'b1; n++) rd_reg(A_STAT, v);
		check("status bit", 1, v[bitn]);
	endtask
	task automatic kick(input bit lf);
		@(posedge mclk);
		if (lf) lfps_pin <= 1'b1;
		else aux_pin <= 1'b1;
		repeat (3) @(posedge mclk);
		lfps_pin <= 1'b0;
		aux_pin <= 1'b0;
		repeat (10) @(posedge mclk);
	endtask
	task automatic run_seq(input int last);
		int e;
		recs.delete();
		gaps.delete();
		for (int k = 0; k <= last; k++) set_blk(k);
		wr_reg(A_CTRL, DW'(last << 1 | 1));
		poll(ST_DONE);
		wr_reg(A_CTRL, 32'h0);
		check("visits", last + 1, recs.size());
		foreach (recs[k]) begin
			e = bval[k] == 0 ? 1 : bval[k];
			check("block", k, recs[k].blk);
			check("pat_sel", bsel[k], recs[k].sel);
			check("general", k == last && bflg[k][1], recs[k].gen);
			if (bflg[k][0]) check("time", e * CYC_US_I, recs[k].cyc);
			else check("reps", e, recs[k].done);
			if (k > 0) check("restart", bflg[k][3], recs[k].first);
			if (!bflg[k][2]) check("skips", k > 0 && bflg[k][3], recs[k].skp);
		end
		check("gaps seen", 1, gaps.size() > 0);
		foreach (gaps[g]) check("gap", 5 * (slow + 1), gaps[g]);
	endtask
	// ------------------------------------------------------------
	// run watchdog and reference record of each block visit
	// ------------------------------------------------------------
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 30000) begin
			num_errors++;
			complete_run();
		end
	end
	always @(posedge mclk) begin
		if (m_on && (!playing || cur_blk != IW'(cur.blk))) begin
			recs.push_back(cur);
			m_on = 1'b0;
		end
		if (playing === 1'b1 && !m_on) begin
			m_on = 1'b1;
			cur = '{cur_blk, 0, 0, pat_sel, pat_general, skip_req, 0};
			last_sk = 0;
		end
		if (m_on) begin
			cur.cyc++;
			cur.done += pat_done;
			if (skip_req) begin
				cur.skp++;
				check("skip_len", exp_len, skip_len);
				if (cur.cyc > 1 && last_sk > 1) gaps.push_back(cur.cyc - last_sk);
				last_sk = cur.cyc;
			end
		end
	end
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		{rstn, wr, rd, aux_pin, lfps_pin, slow, m_on} = '0;
		addr = '0;
		wdata = '0;
		seed = $urandom(32'hb887eb02);
		repeat (6) @(posedge mclk);
		rstn <= 1'b1;
		check("cur_blk", 0, cur_blk);
		rd_reg(A_CTRL, d);
		check("ctrl", 32'he, d);
		wr_reg(A_STAT, 32'hffffffff);
		rd_reg(A_STAT, d);
		check("status", 0, d);
		rd_reg(5'h1f, d);
		check("unmapped", 0, d);
		wr_reg(5'h2, 32'hffffffff);
		rd_reg(5'h2, d);
		check("block word", 32'h3ffffff, d);
		// all blocks share one bitrate, so no idle block is needed
		exp_len = $urandom_range(1, 255);
		wr_reg(A_SKIP, DW'(exp_len | 5 << 8));
		for (int k = 0; k < 4; k++) begin
			bval[k] = $urandom_range(0, 3);
			bsel[k] = $urandom_range(0, 15);
			bflg[k] = 0;
			bbrk[k] = 0;
		end
		bflg[1] = 1;
		bval[1] = $urandom_range(2, 4);
		bflg[2] = 10;
		bflg[3] = 6;
		bval[3] = 12;
		for (int sl = 0; sl < 2; sl++) begin
			slow <= 1'(sl);
			run_seq(3);
		end
		for (int k = 0; k < 3; k++) begin
			bval[k] = 1;
			bflg[k] = 0;
			bbrk[k] = k == 2 ? 0 : k + 1;
			set_blk(k);
		end
		wr_reg(A_CTRL, 32'h5);
		poll(ST_HOLD);
		kick(1'b0);
		check("cur_blk", 0, cur_blk);
		wr_reg(A_CMD, 32'h1);
		repeat (4) @(posedge mclk);
		check("cur_blk", 1, cur_blk);
		poll(ST_HOLD);
		wr_reg(A_CMD, 32'h1);
		repeat (4) @(posedge mclk);
		check("cur_blk", 1, cur_blk);
		kick(1'b0);
		check("cur_blk", 2, cur_blk);
		poll(ST_DONE);
		wr_reg(A_CTRL, 32'h0);
		for (int m = 0; m < 2; m++) begin
			bbrk[0] = 2;
			bbrk[1] = 0;
			set_blk(0);
			set_blk(1);
			wr_reg(A_CTRL, m == 0 ? 32'h33 : 32'h13);
			poll(ST_HOLD);
			kick(m != 0);
			check("cur_blk", 0, cur_blk);
			kick(m == 0);
			check("cur_blk", 1, cur_blk);
			poll(ST_DONE);
			wr_reg(A_CTRL, 32'h0);
		end
		complete_run();
	end
endmodule // pbs_seq_bench
`default_nettype wire
